// File: hdl/dtc_consts.svh
// constants for the dual timer/counter block: SFR addresses, bit positions,
// reset values, prescaler width and pin positions; assumes an 8-bit SFR bus
// Summary of operation
// RULE1 - timer B gated: counts only when irq B pin high and run bit set
// RULE2 - timer B count select: 1 counts pin falling edges, 0 counts machine cycles
// RULE3 - timer B mode 00: 13-bit counter, low byte is 5-bit prescaler
// RULE4 - timer B mode 01: 16-bit counter, low and high bytes cascaded
// RULE5 - timer B mode 10: 8-bit auto-reload, low overflow reloads from high
// RULE6 - timer B mode 11: counting stops, count held unchanged
// RULE7 - timer A gated: counts only when irq A pin high and run bit set
// RULE8 - timer A count select: 1 counts pin falling edges, 0 counts machine cycles
// RULE9 - timer A mode 00: 13-bit timer, low byte is 5-bit prescaler
// RULE10 - timer A mode 01: 16-bit counter, low and high bytes cascaded
// RULE11 - timer A mode 10: 8-bit auto-reload, low overflow reloads from high
// RULE12 - timer A mode 11: splits into two independent 8-bit counters
// RULE13 - split mode: timer A high byte enabled by timer B run bit
// RULE14 - split mode: timer A low byte enabled by (pin OR not gate) AND run
// RULE15 - timer A count in low and high byte registers, read/write, reset zero
// RULE16 - timer B count in low and high byte registers, read/write, reset zero
// RULE17 - mode register: timer B fields bits 7..4, timer A bits 3..0, reset zero
// RULE18 - timer operation increments once per machine cycle, one sixth of clock
// RULE19 - counter operation samples pin once per machine cycle, counts 1 then 0
// RULE20 - upper byte overflow sets that timer's overflow flag
// RULE21 - software sets a timer's run bit to enable it
// RULE22 - split mode: low overflow sets flag A, high overflow sets flag B
// RULE23 - auto-reload mode: high byte keeps its value, only low byte counts
`ifndef DTC_CONSTS_SVH
`define DTC_CONSTS_SVH

// SFR addresses
`define DTC_ADDR_CTRL      8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_A_LOW     8'h8A
`define DTC_ADDR_B_LOW     8'h8B
`define DTC_ADDR_A_HIGH    8'h8C
`define DTC_ADDR_B_HIGH    8'h8D

// reset values
`define DTC_RST_BYTE       8'h00

// control register bits
`define DTC_CTRL_TF_B      7
`define DTC_CTRL_TR_B      6
`define DTC_CTRL_TF_A      5
`define DTC_CTRL_TR_A      4

// mode register fields
`define DTC_MODE_GATE_B    7
`define DTC_MODE_CT_B      6
`define DTC_MODE_M_B_HI    5
`define DTC_MODE_M_B_LO    4
`define DTC_MODE_GATE_A    3
`define DTC_MODE_CT_A      2
`define DTC_MODE_M_A_HI    1
`define DTC_MODE_M_A_LO    0

// prescaler width in the 13-bit mode
`define DTC_PRESC_W        5

// pin vector positions
`define DTC_PIN_IRQ_A      0
`define DTC_PIN_IRQ_B      1
`define DTC_PIN_CNT_A      2
`define DTC_PIN_CNT_B      3

`endif

// File: hdl/dtc_pkg.sv
// types shared by the dual timer/counter block
// assumes dtc_consts.svh supplies the numeric constants
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_MODE_13B    = 2'b00,
        DTC_MODE_16B    = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT  = 2'b11
    } dtc_mode_e;

    // machine cycle states S1..S6
    typedef enum logic [2:0] {
        DTC_S1 = 3'b000,
        DTC_S2 = 3'b001,
        DTC_S3 = 3'b010,
        DTC_S4 = 3'b011,
        DTC_S5 = 3'b100,
        DTC_S6 = 3'b101
    } dtc_phase_e;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic       ovf;
    } dtc_step_s;

    typedef struct packed {
        logic       gate;
        logic       count_sel;
        dtc_mode_e  mode;
    } dtc_cfg_s;

endpackage

// File: hdl/dtc_top.sv
// dual 16-bit timer/counter with its SFR registers
// assumes a CPU SFR port on the same clock; pins are asynchronous
`timescale 1ns/1ps
`include "dtc_consts.svh"

module dtc_top #(
    parameter int SYNC_STAGES = 3
) (
    // clock and reset
    input  wire logic       core_clk_in,
    input  wire logic       rst_in,
    // SFR port
    input  wire logic [7:0] sfr_addr_in,
    input  wire logic       sfr_wr_in,
    input  wire logic       sfr_rd_in,
    input  wire logic [7:0] sfr_wdata_in,
    output logic      [7:0] sfr_rdata_out,
    output logic            sfr_hit_out,
    // external pins
    input  wire logic       ext_irq_a_pin_in,
    input  wire logic       ext_irq_b_pin_in,
    input  wire logic       count_a_pin_in,
    input  wire logic       count_b_pin_in,
    // status
    output logic            timer_a_overflow_flag_out,
    output logic            timer_b_overflow_flag_out
);

    // registers
    logic [7:0]             timer_mode_config_r;
    logic [7:0]             timer_control_reg_r;
    logic [7:0]             timer_a_count_low_r;
    logic [7:0]             timer_a_count_high_r;
    logic [7:0]             timer_b_count_low_r;
    logic [7:0]             timer_b_count_high_r;

    // machine cycle and pin conditioning
    dtc_pkg::dtc_phase_e    phase_r;
    dtc_pkg::dtc_phase_e    phase_nxt;
    logic [3:0]             pin_s1_r;
    logic [3:0]             pin_s2_r;
    logic [3:0]             pin_s3_r;
    logic [3:0]             pin_filt_r;
    logic [1:0]             cnt_prev_r;
    logic [1:0]             cnt_pend_r;

    // decoded controls
    dtc_pkg::dtc_cfg_s      cfg_a;
    dtc_pkg::dtc_cfg_s      cfg_b;
    logic                   run_a;
    logic                   run_b;
    logic                   gate_ok_a;
    logic                   gate_ok_b;
    logic                   inc_a;
    logic                   inc_b;
    logic                   split_a;
    dtc_pkg::dtc_step_s     step_a;
    dtc_pkg::dtc_step_s     step_b;
    logic                   split_hi_ovf;
    logic                   set_tf_a;
    logic                   set_tf_b;

    logic                   wr_ctrl;
    logic                   wr_mode;
    logic                   wr_a_low;
    logic                   wr_a_high;
    logic                   wr_b_low;
    logic                   wr_b_high;

    // one timer step; same arithmetic serves both timers
    function automatic dtc_pkg::dtc_step_s count_step(
        input dtc_pkg::dtc_mode_e mode,
        input logic [7:0]         low,
        input logic [7:0]         high,
        input logic               en
    );
        dtc_pkg::dtc_step_s       res;
        logic [`DTC_PRESC_W:0]    pre;
        logic [8:0]               lsum;
        logic [8:0]               hsum;
        res.low  = low;
        res.high = high;
        res.ovf  = 1'h0;
        pre      = {1'h0, low[`DTC_PRESC_W-1:0]} + {{`DTC_PRESC_W{1'h0}}, 1'h1};
        lsum     = {1'h0, low} + 9'h001;
        hsum     = {1'h0, high} + 9'h001;
        if (en) begin
            case (mode)
                // RULE3 RULE9 5-bit prescale
                dtc_pkg::DTC_MODE_13B: begin
                    res.low[`DTC_PRESC_W-1:0] = pre[`DTC_PRESC_W-1:0];
                    if (pre[`DTC_PRESC_W]) begin
                        res.high = hsum[7:0];
                        // RULE20 upper overflow flag
                        res.ovf  = hsum[8];
                    end
                end
                // RULE4 RULE10 cascaded bytes
                dtc_pkg::DTC_MODE_16B: begin
                    res.low = lsum[7:0];
                    if (lsum[8]) begin
                        res.high = hsum[7:0];
                        res.ovf  = hsum[8];
                    end
                end
                // RULE5 RULE11 RULE23 reload from high
                dtc_pkg::DTC_MODE_RELOAD: begin
                    res.low = lsum[8] ? high : lsum[7:0];
                    res.ovf = lsum[8];
                end
                // RULE6 count frozen
                dtc_pkg::DTC_MODE_SPLIT: begin
                    res.low  = low;
                    res.high = high;
                end
                default: begin
                    res.low  = low;
                    res.high = high;
                end
            endcase
        end
        return res;
    endfunction

    // SFR write strobes
    assign wr_ctrl   = sfr_wr_in && (sfr_addr_in == `DTC_ADDR_CTRL);
    assign wr_mode   = sfr_wr_in && (sfr_addr_in == `DTC_ADDR_MODE);
    assign wr_a_low  = sfr_wr_in && (sfr_addr_in == `DTC_ADDR_A_LOW);
    assign wr_a_high = sfr_wr_in && (sfr_addr_in == `DTC_ADDR_A_HIGH);
    assign wr_b_low  = sfr_wr_in && (sfr_addr_in == `DTC_ADDR_B_LOW);
    assign wr_b_high = sfr_wr_in && (sfr_addr_in == `DTC_ADDR_B_HIGH);

    // RULE17 mode field layout
    assign cfg_b = timer_mode_config_r[`DTC_MODE_GATE_B:`DTC_MODE_M_B_LO];
    assign cfg_a = timer_mode_config_r[`DTC_MODE_GATE_A:`DTC_MODE_M_A_LO];

    // RULE21 run bits from software
    assign run_a = timer_control_reg_r[`DTC_CTRL_TR_A];
    assign run_b = timer_control_reg_r[`DTC_CTRL_TR_B];

    // RULE7 RULE14 gate for timer A
    assign gate_ok_a = run_a && (!cfg_a.gate || pin_filt_r[`DTC_PIN_IRQ_A]);
    // RULE1 gate for timer B
    assign gate_ok_b = run_b && (!cfg_b.gate || pin_filt_r[`DTC_PIN_IRQ_B]);

    // RULE8 timer or counter for A
    assign inc_a = gate_ok_a && (!cfg_a.count_sel || cnt_pend_r[0]);
    // RULE2 timer or counter for B
    assign inc_b = gate_ok_b && (!cfg_b.count_sel || cnt_pend_r[1]);

    assign split_a = (cfg_a.mode == dtc_pkg::DTC_MODE_SPLIT);

    always_comb begin
        logic [8:0] lsum;
        logic [8:0] hsum;
        lsum         = {1'h0, timer_a_count_low_r} + 9'h001;
        hsum         = {1'h0, timer_a_count_high_r} + 9'h001;
        split_hi_ovf = 1'h0;
        if (split_a) begin
            // RULE12 two independent 8-bit counters
            step_a.low  = inc_a ? lsum[7:0] : timer_a_count_low_r;
            step_a.ovf  = inc_a && lsum[8];
            step_a.high = timer_a_count_high_r;
            // RULE13 high byte runs on timer B run bit
            if (run_b) begin
                step_a.high  = hsum[7:0];
                split_hi_ovf = hsum[8];
            end
        end else begin
            step_a = count_step(cfg_a.mode, timer_a_count_low_r,
                                timer_a_count_high_r, inc_a);
        end
    end

    always_comb begin
        step_b = count_step(cfg_b.mode, timer_b_count_low_r,
                            timer_b_count_high_r, inc_b);
    end

    // RULE22 split overflows to both flags
    assign set_tf_a = (phase_r == dtc_pkg::DTC_S1) && step_a.ovf;
    assign set_tf_b = ((phase_r == dtc_pkg::DTC_S3) && step_b.ovf) ||
                      ((phase_r == dtc_pkg::DTC_S1) && split_hi_ovf);

    // RULE18 six-state machine cycle
    always_comb begin
        case (phase_r)
            dtc_pkg::DTC_S1: phase_nxt = dtc_pkg::DTC_S2;
            dtc_pkg::DTC_S2: phase_nxt = dtc_pkg::DTC_S3;
            dtc_pkg::DTC_S3: phase_nxt = dtc_pkg::DTC_S4;
            dtc_pkg::DTC_S4: phase_nxt = dtc_pkg::DTC_S5;
            dtc_pkg::DTC_S5: phase_nxt = dtc_pkg::DTC_S6;
            dtc_pkg::DTC_S6: phase_nxt = dtc_pkg::DTC_S1;
            default:         phase_nxt = dtc_pkg::DTC_S1;
        endcase
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            phase_r <= dtc_pkg::DTC_S1;
        end else begin
            phase_r <= phase_nxt;
        end
    end

    // pins are asynchronous; level moves once the last two stages agree
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pin_s1_r   <= 4'h0;
            pin_s2_r   <= 4'h0;
            pin_s3_r   <= 4'h0;
            pin_filt_r <= 4'h0;
        end else begin
            pin_s1_r   <= {count_b_pin_in, count_a_pin_in,
                           ext_irq_b_pin_in, ext_irq_a_pin_in};
            pin_s2_r   <= pin_s1_r;
            pin_s3_r   <= pin_s2_r;
            pin_filt_r <= (pin_s2_r & pin_s3_r) |
                          (pin_filt_r & (pin_s2_r | pin_s3_r));
        end
    end

    // RULE19 sampled once per cycle, 1 then 0
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            cnt_prev_r <= 2'h0;
            cnt_pend_r <= 2'h0;
        end else begin
            if (phase_r == dtc_pkg::DTC_S5) begin
                cnt_prev_r <= pin_filt_r[`DTC_PIN_CNT_B:`DTC_PIN_CNT_A];
                cnt_pend_r <= cnt_pend_r |
                              (cnt_prev_r & ~pin_filt_r[`DTC_PIN_CNT_B:`DTC_PIN_CNT_A]);
            end else begin
                // edge consumed at the timer's own increment state
                if (phase_r == dtc_pkg::DTC_S1) begin
                    cnt_pend_r[0] <= 1'h0;
                end
                if (phase_r == dtc_pkg::DTC_S3) begin
                    cnt_pend_r[1] <= 1'h0;
                end
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            timer_mode_config_r <= `DTC_RST_BYTE;
        end else if (wr_mode) begin
            timer_mode_config_r <= sfr_wdata_in;
        end
    end

    // hardware set beats a software clear in the same cycle
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            timer_control_reg_r <= `DTC_RST_BYTE;
        end else begin
            if (wr_ctrl) begin
                timer_control_reg_r <= sfr_wdata_in;
            end
            // RULE20 overflow sets flag
            if (set_tf_a) begin
                timer_control_reg_r[`DTC_CTRL_TF_A] <= 1'h1;
            end
            if (set_tf_b) begin
                timer_control_reg_r[`DTC_CTRL_TF_B] <= 1'h1;
            end
        end
    end

    // RULE15 timer A bytes; software write overrides the hardware step
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            timer_a_count_low_r  <= `DTC_RST_BYTE;
            timer_a_count_high_r <= `DTC_RST_BYTE;
        end else begin
            if (phase_r == dtc_pkg::DTC_S1) begin
                timer_a_count_low_r  <= step_a.low;
                timer_a_count_high_r <= step_a.high;
            end
            if (wr_a_low) begin
                timer_a_count_low_r <= sfr_wdata_in;
            end
            if (wr_a_high) begin
                timer_a_count_high_r <= sfr_wdata_in;
            end
        end
    end

    // RULE16 timer B bytes; software write overrides the hardware step
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            timer_b_count_low_r  <= `DTC_RST_BYTE;
            timer_b_count_high_r <= `DTC_RST_BYTE;
        end else begin
            if (phase_r == dtc_pkg::DTC_S3) begin
                timer_b_count_low_r  <= step_b.low;
                timer_b_count_high_r <= step_b.high;
            end
            if (wr_b_low) begin
                timer_b_count_low_r <= sfr_wdata_in;
            end
            if (wr_b_high) begin
                timer_b_count_high_r <= sfr_wdata_in;
            end
        end
    end

    // read data registered; unmapped addresses answer zero with no hit
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            sfr_rdata_out <= `DTC_RST_BYTE;
            sfr_hit_out   <= 1'h0;
        end else begin
            sfr_hit_out   <= 1'h0;
            sfr_rdata_out <= `DTC_RST_BYTE;
            if (sfr_rd_in) begin
                sfr_hit_out <= 1'h1;
                case (sfr_addr_in)
                    `DTC_ADDR_CTRL:   sfr_rdata_out <= timer_control_reg_r;
                    `DTC_ADDR_MODE:   sfr_rdata_out <= timer_mode_config_r;
                    `DTC_ADDR_A_LOW:  sfr_rdata_out <= timer_a_count_low_r;
                    `DTC_ADDR_B_LOW:  sfr_rdata_out <= timer_b_count_low_r;
                    `DTC_ADDR_A_HIGH: sfr_rdata_out <= timer_a_count_high_r;
                    `DTC_ADDR_B_HIGH: sfr_rdata_out <= timer_b_count_high_r;
                    default: begin
                        sfr_hit_out   <= 1'h0;
                        sfr_rdata_out <= `DTC_RST_BYTE;
                    end
                endcase
            end
        end
    end

    // flags come straight from the control register flops
    assign timer_a_overflow_flag_out = timer_control_reg_r[`DTC_CTRL_TF_A];
    assign timer_b_overflow_flag_out = timer_control_reg_r[`DTC_CTRL_TF_B];

endmodule

// File: dv/dtc_props.sv
// checker for the timer block's SFR port and overflow flags
// assumes it is bound to dtc_top and sees only its ports
`timescale 1ns/1ps
module dtc_props (
    // clock and reset
    input wire logic       core_clk_in,
    input wire logic       rst_in,
    // SFR port
    input wire logic [7:0] sfr_addr_in,
    input wire logic       sfr_wr_in,
    input wire logic       sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic       sfr_hit_out,
    // status
    input wire logic       timer_a_overflow_flag_out,
    input wire logic       timer_b_overflow_flag_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic mapped;
    logic ctl_wr;
    assign mapped = (sfr_addr_in >= 8'h88) && (sfr_addr_in <= 8'h8D);
    assign ctl_wr = sfr_wr_in && (sfr_addr_in == 8'h88);

    a_hit_mapped: assert property (sfr_rd_in && mapped |=> sfr_hit_out)
        else $error("mapped read gave no hit");
    a_read_miss: assert property (sfr_rd_in && !mapped |=> !sfr_hit_out && sfr_rdata_out == 8'h00)
        else $error("unmapped read not refused");
    a_rdata_idle: assert property (!sfr_rd_in |=> sfr_rdata_out == 8'h00)
        else $error("read data not zero without a read");
    a_hit_idle: assert property (!sfr_rd_in |=> !sfr_hit_out)
        else $error("hit high without a read");
    a_flags_reset: assert property ($fell(rst_in) |-> !timer_a_overflow_flag_out
        && !timer_b_overflow_flag_out)
        else $error("flags not clear after reset");
    a_mode_readback: assert property (sfr_wr_in && sfr_addr_in == 8'h89
        ##1 !(sfr_wr_in && sfr_addr_in == 8'h89)
        ##1 (sfr_rd_in && !sfr_wr_in && sfr_addr_in == 8'h89)
        |=> sfr_rdata_out == $past(sfr_wdata_in, 3))
        else $error("mode register read back wrong");
    a_flag_a_hold: assert property (timer_a_overflow_flag_out && !ctl_wr
        |=> timer_a_overflow_flag_out)
        else $error("timer A flag dropped without a write");
    a_flag_b_hold: assert property (timer_b_overflow_flag_out && !ctl_wr
        |=> timer_b_overflow_flag_out)
        else $error("timer B flag dropped without a write");
    a_flag_sw_set: assert property (ctl_wr && sfr_wdata_in[7] && sfr_wdata_in[5]
        |=> timer_a_overflow_flag_out && timer_b_overflow_flag_out)
        else $error("flags not written by software");
endmodule

bind dtc_top dtc_props dtc_props_i (
    .core_clk_in               (core_clk_in),
    .rst_in                    (rst_in),
    .sfr_addr_in               (sfr_addr_in),
    .sfr_wr_in                 (sfr_wr_in),
    .sfr_rd_in                 (sfr_rd_in),
    .sfr_wdata_in              (sfr_wdata_in),
    .sfr_rdata_out             (sfr_rdata_out),
    .sfr_hit_out               (sfr_hit_out),
    .timer_a_overflow_flag_out (timer_a_overflow_flag_out),
    .timer_b_overflow_flag_out (timer_b_overflow_flag_out)
);

// File: dv/test_dual_timer_counter_modes.sv
// self-checking bench for the dual timer: SFR access, all modes, gating, counting
// assumes dtc_top with the checker bound; runs are windows of whole machine cycles
`timescale 1ns/1ps
module test_dual_timer_counter_modes;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rdata;
    logic        hit;
    logic        irq_a = 1'b0;
    logic        irq_b = 1'b0;
    logic        cnt_pin = 1'b1;
    logic        fa;
    logic        fb;
    logic        seen_a = 1'b0;
    logic        seen_b = 1'b0;
    logic        clr_seen = 1'b0;
    logic [31:0] rs = 32'd6;
    logic [7:0]  cnt [4];
    logic [7:0]  ex [4];
    logic        ex_fa;
    logic        ex_fb;
    int          bad_count = 0;
    int          compares = 0;

    dtc_top dtc_top_i (
        .core_clk_in               (clk),
        .rst_in                    (rst),
        .sfr_addr_in               (addr),
        .sfr_wr_in                 (wr),
        .sfr_rd_in                 (rd),
        .sfr_wdata_in              (wdata),
        .sfr_rdata_out             (rdata),
        .sfr_hit_out               (hit),
        .ext_irq_a_pin_in          (irq_a),
        .ext_irq_b_pin_in          (irq_b),
        .count_a_pin_in            (cnt_pin),
        .count_b_pin_in            (cnt_pin),
        .timer_a_overflow_flag_out (fa),
        .timer_b_overflow_flag_out (fb)
    );

    always #25 clk = ~clk;

    // flags are cleared by the stop write, so latch any set seen during a run
    always @(posedge clk) begin
        seen_a <= clr_seen ? 1'b0 : (seen_a | (fa === 1'b1));
        seen_b <= clr_seen ? 1'b0 : (seen_b | (fb === 1'b1));
    end

    function automatic logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction

    // md 3 here means a plain 8-bit byte, as in split operation
    function automatic logic adv(input int lo, input int hi, input logic [1:0] md, input int k);
        logic ovf = 1'b0;
        for (int i = 0; i < k; i++) begin
            case (md)
                2'b00: begin
                    ex[lo][4:0] = ex[lo][4:0] + 5'h01;
                    if (ex[lo][4:0] == 5'h00) begin
                        ex[hi] = ex[hi] + 8'h01;
                        ovf = ovf | (ex[hi] == 8'h00);
                    end
                end
                2'b01: begin
                    {ex[hi], ex[lo]} = {ex[hi], ex[lo]} + 16'h0001;
                    ovf = ovf | ({ex[hi], ex[lo]} == 16'h0000);
                end
                2'b10: begin
                    ex[lo] = ex[lo] + 8'h01;
                    if (ex[lo] == 8'h00) begin
                        ex[lo] = ex[hi];
                        ovf = 1'b1;
                    end
                end
                default: begin
                    ex[lo] = ex[lo] + 8'h01;
                    ovf = ovf | (ex[lo] == 8'h00);
                end
            endcase
        end
        return ovf;
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wrap_up();
        if (bad_count == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic sfr_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
        check({7'h00, hit}, {7'h00, (a >= 8'h88 && a <= 8'h8D)});
    endtask

    // run window is exactly 6*k clocks from run-on write to run-off write
    task automatic run_case(input logic [7:0] md, input logic [7:0] ctl, input int k,
                            input int n);
        sfr_wr(8'h89, md);
        for (int i = 0; i < 4; i++) sfr_wr(8'h8A + i[7:0], cnt[i]);
        ex = cnt;
        clr_seen <= 1'b1;
        sfr_wr(8'h88, ctl);
        clr_seen <= 1'b0;
        for (int i = 0; i < 6 * k - 2; i++) begin
            @(posedge clk);
            cnt_pin <= (i >= 24 * n) || (i % 24 < 12);
        end
        sfr_wr(8'h88, 8'h00);
        repeat (3) @(posedge clk);
    endtask

    task automatic check_case();
        for (int i = 0; i < 4; i++) sfr_chk(8'h8A + i[7:0], ex[i]);
        check({6'h00, seen_b, seen_a}, {6'h00, ex_fb, ex_fa});
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] md;
        logic       ovf;
        int         k;
        int         n;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        for (int i = 8'h87; i <= 8'h8E; i++) sfr_chk(i[7:0], 8'h00);
        sfr_wr(8'h88, 8'hA0);
        sfr_wr(8'h88, 8'h00);
        repeat (8) begin
            a = 8'h89 + (rnd() % 8'd5);
            d = rnd();
            sfr_wr(a, d);
            sfr_chk(a, d);
        end
        // timer operation, modes 0-2 of timer A and every mode of timer B; first trial overflows except in timer B mode 3
        for (int t = 0; t < 2; t++) for (int m = 0; m < 4; m++) for (int j = 0; j < 3; j++) begin
            if (t == 0 && m == 3) continue;
            foreach (cnt[i]) cnt[i] = rnd();
            if (j == 0) begin
                cnt[t] = 8'hFF;
                cnt[t + 2] = 8'hFF;
            end
            k = (j == 0) ? 3 : 1 + int'(rnd() % 8'd40);
            md = (t == 0) ? {6'h0C, m[1:0]} : {2'b00, m[1:0], 4'h0};
            run_case(md, (t == 0) ? 8'h10 : 8'h40, k, 0);
            // timer B in mode 3 holds its count and never overflows
            ovf = (t == 1 && m == 3) ? 1'b0 : adv(t, t + 2, m[1:0], k);
            ex_fa = (t == 0) & ovf;
            ex_fb = (t == 1) & ovf;
            check_case();
        end
        // split: low byte on its own run bit, high byte on the other timer's
        for (int t = 0; t < 2; t++) begin
            foreach (cnt[i]) cnt[i] = rnd();
            cnt[2 * t] = 8'hFE;
            k = 2 + int'(rnd() % 8'd20);
            run_case(8'h33, (t == 0) ? 8'h10 : 8'h40, k, 0);
            ovf = adv(2 * t, 2 * t, 2'b11, k);
            ex_fa = (t == 0) & ovf;
            ex_fb = (t == 1) & ovf;
            check_case();
        end
        // gate pin low, gate pin high, then counting pin edges
        for (int t = 0; t < 2; t++) for (int c = 0; c < 3; c++) begin
            irq_a <= (c != 0);
            irq_b <= (c != 0);
            n = (c == 2) ? 1 + int'(rnd() % 8'd4) : 0;
            k = (c == 2) ? 4 * n + 4 : 1 + int'(rnd() % 8'd30);
            md = (c == 2) ? ((t == 0) ? 8'h35 : 8'h50) : ((t == 0) ? 8'h39 : 8'h90);
            foreach (cnt[i]) cnt[i] = rnd();
            run_case(md, (t == 0) ? 8'h10 : 8'h40, k, n);
            ovf = (c == 0) ? 1'b0 : adv(t, t + 2, 2'b01, (c == 2) ? n : k);
            ex_fa = (t == 0) & ovf;
            ex_fb = (t == 1) & ovf;
            check_case();
        end
        wrap_up();
    end
endmodule
